// >>> hdl/srer_top.sv
// streaming read command: address task file, time limit and error report
//
// What this block does
// - 48-bit address bytes: current halves bits 23:0, previous halves bits 47:24.
// - with continuous read, error returns first failing address; high half when byte select set.
// - on that error, sector count holds consecutive suspect sectors from that address.
// - completion-time-exceeded, error bit 0, is set when the time limit runs out.
// - stream-error status bit 5 is set on any error under continuous read.
// - under continuous read errors set stream error, clear error flag, go to error log.
// - time limit expiry under continuous read stops the command, busy clears, logged.
`timescale 1ns/1ps
module srer_top #(
   // time limit unit per feature step, and the device floor; long, so shortenable
   parameter logic [15:0] COMPLETION_TIME_LIMIT_UNIT_US = 16'h000A,
   parameter logic [23:0] COMPLETION_TIME_LIMIT_MIN_US  = 24'h000001
) (
   // clock and reset
   input  wire logic                        clock,
   input  wire logic                        rst_b,
   // register port
   input  wire logic [srer_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [7:0]                  regWrData,
   input  wire logic                        regWrEn,
   input  wire logic                        regRdEn,
   output logic      [7:0]                  regRdData,
   // media engine events
   input  wire logic                        errValid,
   input  wire logic [srer_pkg::KIND_W-1:0] errKind,
   input  wire logic [srer_pkg::LBA_W-1:0]  errLba,
   input  wire logic                        xferDone,
   // media engine control
   output logic                             xferBusy,
   output logic                             rcMode,
   output logic      [srer_pkg::LBA_W-1:0]  startLba,
   output logic      [srer_pkg::CNT_W-1:0]  sectorCount,
   output logic                             stopXfer,
   // interrupt
   output logic                             irq
);
   localparam int BW = srer_pkg::BYTE_W;

   function automatic logic [7:0] lbaByte(input logic [srer_pkg::LBA_W-1:0] v,
                                          input int idx);
      lbaByte = v[idx*BW +: BW];
   endfunction

   function automatic logic [7:0] kindBits(input logic [srer_pkg::KIND_W-1:0] k);
      kindBits = (8'(k[srer_pkg::KIND_CRC])  << srer_pkg::ERR_CRC_BIT)
               | (8'(k[srer_pkg::KIND_UNC])  << srer_pkg::ERR_UNC_BIT)
               | (8'(k[srer_pkg::KIND_SECTOR_NOT_FOUND_ERROR]) << srer_pkg::ERR_SECTOR_NOT_FOUND_ERROR_BIT)
               | (8'(k[srer_pkg::KIND_COMMAND_ABORTED_ERROR]) << srer_pkg::ERR_COMMAND_ABORTED_ERROR_BIT);
   endfunction

   function automatic logic [7:0] bitMask(input int pos);
      bitMask = 8'h01 << pos;
   endfunction

   // task file
   logic [7:0] featCur_q;
   logic [7:0] featPrev_q;
   logic [7:0] cntCur_q;
   logic [7:0] cntPrev_q;
   logic [7:0] lbaCur_q  [0:srer_pkg::LBA_BYTES_HALF-1];
   logic [7:0] lbaPrev_q [0:srer_pkg::LBA_BYTES_HALF-1];
   logic       hob_q;

   // command state and report
   srer_pkg::srer_state_t state_q;
   srer_pkg::srer_state_t state_d;
   logic [7:0]            errReg_q;
   logic [7:0]            errLog_q;
   logic                  seFlag_q;
   logic                  errStat_q;
   logic                  rc_q;
   logic                  busy_q;
   logic                  stop_q;
   logic [srer_pkg::LBA_W-1:0] startLba_q;
   logic [srer_pkg::CNT_W-1:0] secCnt_q;

   // register port and interrupt
   logic [7:0]               rdData_q;
   logic [srer_pkg::IRQ_W-1:0] irqStat_q;
   logic [srer_pkg::IRQ_W-1:0] irqMask_q;
   logic                     irq_q;

   // sub-block results
   logic                       timerExpire;
   logic                       haveFail;
   logic [srer_pkg::LBA_W-1:0] firstLba;
   logic [srer_pkg::CNT_W-1:0] suspectCnt;

   // decode
   wire idle      = (state_q == srer_pkg::ST_IDLE);
   wire running   = (state_q == srer_pkg::ST_RUN);
   wire finishing = (state_q == srer_pkg::ST_FIN);
   wire wrFeat    = regWrEn && idle && (regAddr == srer_pkg::REG_FEATURE);
   wire wrCnt     = regWrEn && idle && (regAddr == srer_pkg::REG_SECCNT);
   wire wrLbaLo   = regWrEn && idle && (regAddr == srer_pkg::REG_LBA_LO);
   wire wrLbaMid  = regWrEn && idle && (regAddr == srer_pkg::REG_LBA_MID);
   wire wrLbaHi   = regWrEn && idle && (regAddr == srer_pkg::REG_LBA_HI);
   wire wrCtrl    = regWrEn && (regAddr == srer_pkg::REG_CTRL_ERR);
   wire wrMask    = regWrEn && (regAddr == srer_pkg::REG_IRQ_MASK);
   wire wrTask    = wrFeat || wrCnt || wrLbaLo || wrLbaMid || wrLbaHi;
   // a command write while busy is dropped, as the interface would
   wire cmdStart  = regWrEn && idle && (regAddr == srer_pkg::REG_CMD_STAT)
                    && (regWrData == srer_pkg::CMD_READ_STREAM);
   wire irqRdClr  = regRdEn && (regAddr == srer_pkg::REG_IRQ_STAT);

   // assembled address and requested count
   wire [srer_pkg::LBA_W-1:0] taskLba = {lbaPrev_q[2], lbaPrev_q[1], lbaPrev_q[0],
                                         lbaCur_q[2],  lbaCur_q[1],  lbaCur_q[0]};
   wire [srer_pkg::CNT_W-1:0] taskCnt = {cntPrev_q, cntCur_q};
   wire                       taskRc  = featCur_q[srer_pkg::FEAT_RC_BIT];

   // time limit in microseconds; zero means no limit is applied
   wire [srer_pkg::LIM_W-1:0] rawLimUs = srer_pkg::LIM_W'(featPrev_q) *
                                         srer_pkg::LIM_W'(COMPLETION_TIME_LIMIT_UNIT_US);
   wire [srer_pkg::LIM_W-1:0] limUs    = (rawLimUs < COMPLETION_TIME_LIMIT_MIN_US) ? COMPLETION_TIME_LIMIT_MIN_US : rawLimUs;
   wire                       limOn    = (featPrev_q != srer_pkg::BYTE_RST);

   // error events during the run
   wire       runErr     = running && errValid;
   wire       runExp     = running && timerExpire;
   wire       anyFault   = runErr || runExp;
   wire [7:0] faultBits  = (runErr ? kindBits(errKind) : 8'h00)
                         | (runExp ? bitMask(srer_pkg::ERR_COMPLETION_TIME_EXCEEDED_BIT) : 8'h00);
   // continuous read keeps going on data errors; only the limit stops it
   wire       abandon    = runExp || (runErr && !rc_q);
   wire [7:0] errRegSet  = (rc_q ? 8'h00 : faultBits)
                         | (runExp ? bitMask(srer_pkg::ERR_COMPLETION_TIME_EXCEEDED_BIT) : 8'h00);
   wire [7:0] errLogSet  = rc_q ? faultBits : 8'h00;
   wire       seSet      = rc_q && anyFault;
   wire       errStatSet = !rc_q && anyFault;

   // interrupt events: command ending, first stream error of a command
   wire [srer_pkg::IRQ_W-1:0] irqSet =
        (srer_pkg::IRQ_W'(finishing) << srer_pkg::IRQ_DONE_BIT)
      | (srer_pkg::IRQ_W'(seSet && !seFlag_q) << srer_pkg::IRQ_SE_BIT);
   localparam logic [srer_pkg::IRQ_W-1:0] IRQ_ZERO = srer_pkg::IRQ_RST;
   // a new event in the clearing read cycle survives the clear
   wire [srer_pkg::IRQ_W-1:0] irqStat_d = (irqRdClr ? IRQ_ZERO : irqStat_q) | irqSet;

   // status byte
   wire [7:0] statusByte = (8'(busy_q)    << srer_pkg::STAT_BSY_BIT)
                         | bitMask(srer_pkg::STAT_RDY_BIT)
                         | (8'(seFlag_q)  << srer_pkg::STAT_SE_BIT)
                         | (8'(errStat_q) << srer_pkg::STAT_ERR_BIT);

   // read selection; the byte select picks the previous halves
   wire [7:0] rdFeat = hob_q ? featPrev_q   : featCur_q;
   wire [7:0] rdCnt  = hob_q ? cntPrev_q    : cntCur_q;
   wire [7:0] rdLo   = hob_q ? lbaPrev_q[0] : lbaCur_q[0];
   wire [7:0] rdMid  = hob_q ? lbaPrev_q[1] : lbaCur_q[1];
   wire [7:0] rdHi   = hob_q ? lbaPrev_q[2] : lbaCur_q[2];
   wire [7:0] rdMux  =
        (regAddr == srer_pkg::REG_FEATURE)  ? rdFeat :
        (regAddr == srer_pkg::REG_SECCNT)   ? rdCnt :
        (regAddr == srer_pkg::REG_LBA_LO)   ? rdLo :
        (regAddr == srer_pkg::REG_LBA_MID)  ? rdMid :
        (regAddr == srer_pkg::REG_LBA_HI)   ? rdHi :
        (regAddr == srer_pkg::REG_CMD_STAT) ? statusByte :
        (regAddr == srer_pkg::REG_CTRL_ERR) ? errReg_q :
        (regAddr == srer_pkg::REG_ERR_LOG)  ? errLog_q :
        (regAddr == srer_pkg::REG_IRQ_STAT) ? 8'(irqStat_q) :
        (regAddr == srer_pkg::REG_IRQ_MASK) ? 8'(irqMask_q) : 8'h00;

   // command sequencer
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         srer_pkg::ST_IDLE: if (cmdStart) state_d = srer_pkg::ST_RUN;
         srer_pkg::ST_RUN:  if (abandon || xferDone) state_d = srer_pkg::ST_FIN;
         srer_pkg::ST_FIN:  state_d = srer_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= srer_pkg::ST_IDLE;
         busy_q  <= 1'b0;
         stop_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         busy_q  <= (state_d != srer_pkg::ST_IDLE);
         stop_q  <= abandon;
      end
   end

   // task file: a host write pushes the current half into the previous half
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         featCur_q  <= srer_pkg::BYTE_RST;
         featPrev_q <= srer_pkg::BYTE_RST;
         cntCur_q   <= srer_pkg::BYTE_RST;
         cntPrev_q  <= srer_pkg::BYTE_RST;
         hob_q      <= 1'b0;
         for (int i = 0; i < srer_pkg::LBA_BYTES_HALF; i++) begin
            lbaCur_q[i]  <= srer_pkg::BYTE_RST;
            lbaPrev_q[i] <= srer_pkg::BYTE_RST;
         end
      end else begin
         if (wrCtrl) begin
            hob_q <= regWrData[srer_pkg::CTRL_HOB_BIT];
         end else if (wrTask) begin
            hob_q <= 1'b0;
         end
         if (wrFeat) begin
            featPrev_q <= featCur_q;
            featCur_q  <= regWrData;
         end
         if (wrCnt) begin
            cntPrev_q <= cntCur_q;
            cntCur_q  <= regWrData;
         end
         if (wrLbaLo) begin
            lbaPrev_q[0] <= lbaCur_q[0];
            lbaCur_q[0]  <= regWrData;
         end
         if (wrLbaMid) begin
            lbaPrev_q[1] <= lbaCur_q[1];
            lbaCur_q[1]  <= regWrData;
         end
         if (wrLbaHi) begin
            lbaPrev_q[2] <= lbaCur_q[2];
            lbaCur_q[2]  <= regWrData;
         end
         // report loaded as busy drops, so it is settled before the host may look
         if (finishing && haveFail) begin
            for (int i = 0; i < srer_pkg::LBA_BYTES_HALF; i++) begin
               lbaCur_q[i]  <= lbaByte(firstLba, i);
               lbaPrev_q[i] <= lbaByte(firstLba, i + srer_pkg::LBA_BYTES_HALF);
            end
            cntCur_q  <= suspectCnt[BW-1:0];
            cntPrev_q <= suspectCnt[srer_pkg::CNT_W-1:BW];
         end
      end
   end

   // command parameters latched for the engine and the error report
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rc_q       <= 1'b0;
         startLba_q <= '0;
         secCnt_q   <= '0;
         errReg_q   <= srer_pkg::BYTE_RST;
         errLog_q   <= srer_pkg::BYTE_RST;
         seFlag_q   <= 1'b0;
         errStat_q  <= 1'b0;
      end else if (cmdStart) begin
         rc_q       <= taskRc;
         startLba_q <= taskLba;
         secCnt_q   <= taskCnt;
         errReg_q   <= srer_pkg::BYTE_RST;
         errLog_q   <= srer_pkg::BYTE_RST;
         seFlag_q   <= 1'b0;
         errStat_q  <= 1'b0;
      end else begin
         errReg_q  <= errReg_q | errRegSet;
         errLog_q  <= errLog_q | errLogSet;
         seFlag_q  <= seFlag_q | seSet;
         errStat_q <= errStat_q | errStatSet;
      end
   end

   // register port read data and interrupt
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdData_q  <= srer_pkg::BYTE_RST;
         irqStat_q <= srer_pkg::IRQ_RST;
         irqMask_q <= srer_pkg::IRQ_RST;
         irq_q     <= 1'b0;
      end else begin
         rdData_q  <= regRdEn ? rdMux : srer_pkg::BYTE_RST;
         irqStat_q <= irqStat_d;
         irq_q     <= |(irqStat_q & irqMask_q);
         if (wrMask) begin
            irqMask_q <= regWrData[srer_pkg::IRQ_W-1:0];
         end
      end
   end

   srer_completion_time_limit_timer u_timer (
      .clock   (clock),
      .rst_b   (rst_b),
      .start   (cmdStart && limOn),
      .stop    (!running),
      .limitUs (limUs),
      .expire  (timerExpire)
   );

   srer_fail_capture u_capture (
      .clock      (clock),
      .rst_b      (rst_b),
      .start      (cmdStart),
      .errValid   (runErr),
      .errLba     (errLba),
      .haveFail   (haveFail),
      .firstLba   (firstLba),
      .suspectCnt (suspectCnt)
   );

   assign regRdData   = rdData_q;
   assign xferBusy    = busy_q;
   assign rcMode      = rc_q;
   assign startLba    = startLba_q;
   assign sectorCount = secCnt_q;
   assign stopXfer    = stop_q;
   assign irq         = irq_q;

   property p_lba_split;
      @(posedge clock) disable iff (!rst_b)
         cmdStart |=> (startLba_q[5*BW +: BW] == $past(lbaPrev_q[2]))
                   && (startLba_q[0 +: BW] == $past(lbaCur_q[0]));
   endproperty
   a_lba_split: assert property (p_lba_split)
      else $error("start address bytes misplaced");

   property p_hob_read;
      @(posedge clock) disable iff (!rst_b)
         (regRdEn && regAddr == srer_pkg::REG_LBA_HI && hob_q)
            |=> (regRdData == $past(lbaPrev_q[2]));
   endproperty
   a_hob_read: assert property (p_hob_read)
      else $error("high half not returned with byte select set");

   property p_cnt_load;
      @(posedge clock) disable iff (!rst_b)
         (finishing && haveFail) |=> ({cntPrev_q, cntCur_q} == $past(suspectCnt));
   endproperty
   a_cnt_load: assert property (p_cnt_load)
      else $error("suspect count not loaded");

   property p_completion_time_exceeded;
      @(posedge clock) disable iff (!rst_b)
         (runExp && !cmdStart) |=> errReg_q[srer_pkg::ERR_COMPLETION_TIME_EXCEEDED_BIT] ##1 !busy_q;
   endproperty
   a_completion_time_exceeded: assert property (p_completion_time_exceeded)
      else $error("time limit flag missing");

   property p_se;
      @(posedge clock) disable iff (!rst_b)
         (runErr && rc_q) |=> seFlag_q && statusByte[srer_pkg::STAT_SE_BIT];
   endproperty
   a_se: assert property (p_se)
      else $error("stream error flag not set");

   property p_no_err;
      @(posedge clock) disable iff (!rst_b)
         (rc_q && !idle) |-> !errStat_q && !statusByte[srer_pkg::STAT_ERR_BIT];
   endproperty
   a_no_err: assert property (p_no_err)
      else $error("error flag set under continuous read");

   property p_stop;
      @(posedge clock) disable iff (!rst_b)
         runExp |=> stopXfer ##1 (!xferBusy && idle);
   endproperty
   a_stop: assert property (p_stop)
      else $error("command did not stop on time limit");

   property p_keep_going;
      @(posedge clock) disable iff (!rst_b)
         (runErr && rc_q && !runExp && !xferDone) |=> (running && !stopXfer);
   endproperty
   a_keep_going: assert property (p_keep_going)
      else $error("continuous read abandoned on data error");

   property p_irq;
      @(posedge clock) disable iff (!rst_b)
         (|(irqStat_q & irqMask_q)) |=> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("unmasked event did not raise interrupt");
endmodule // srer_top

// >>> common/srer_pkg.sv
// constants shared by the stream read error report block
package srer_pkg;
   // widths
   localparam int ADDR_W = 4;
   localparam int BYTE_W = 8;
   localparam int LBA_W  = 48;
   localparam int CNT_W  = 16;
   localparam int LIM_W  = 24;
   localparam int LBA_BYTES_HALF = 3;

   // register indices on the register port
   localparam logic [ADDR_W-1:0] REG_FEATURE  = 4'h0;
   localparam logic [ADDR_W-1:0] REG_SECCNT   = 4'h1;
   localparam logic [ADDR_W-1:0] REG_LBA_LO   = 4'h2;
   localparam logic [ADDR_W-1:0] REG_LBA_MID  = 4'h3;
   localparam logic [ADDR_W-1:0] REG_LBA_HI   = 4'h4;
   localparam logic [ADDR_W-1:0] REG_CMD_STAT = 4'h5;
   localparam logic [ADDR_W-1:0] REG_CTRL_ERR = 4'h6;
   localparam logic [ADDR_W-1:0] REG_ERR_LOG  = 4'h7;
   localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h8;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h9;

   // command opcode that starts a streaming read
   localparam logic [BYTE_W-1:0] CMD_READ_STREAM = 8'h2B;

   // field positions
   localparam int FEAT_RC_BIT   = 6;
   localparam int CTRL_HOB_BIT  = 7;
   localparam int ERR_COMPLETION_TIME_EXCEEDED_BIT  = 0;
   localparam int ERR_COMMAND_ABORTED_ERROR_BIT  = 2;
   localparam int ERR_SECTOR_NOT_FOUND_ERROR_BIT  = 4;
   localparam int ERR_UNC_BIT   = 6;
   localparam int ERR_CRC_BIT   = 7;
   localparam int STAT_BSY_BIT  = 7;
   localparam int STAT_RDY_BIT  = 6;
   localparam int STAT_SE_BIT   = 5;
   localparam int STAT_ERR_BIT  = 0;
   localparam int IRQ_DONE_BIT  = 0;
   localparam int IRQ_SE_BIT    = 1;
   localparam int IRQ_W         = 2;

   // error kind vector from the media engine
   localparam int KIND_CRC  = 0;
   localparam int KIND_UNC  = 1;
   localparam int KIND_SECTOR_NOT_FOUND_ERROR = 2;
   localparam int KIND_COMMAND_ABORTED_ERROR = 3;
   localparam int KIND_W    = 4;

   // reset values
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
   localparam logic [IRQ_W-1:0]  IRQ_RST  = 2'h0;

   // timing: one microsecond tick at the 8 ns clock
   localparam int CLK_PERIOD_PS = 8000;
   localparam int US_PS         = 1000000;
   localparam int CYC_PER_US    = US_PS / CLK_PERIOD_PS;
   localparam int PRE_W         = 7;
   localparam logic [PRE_W-1:0] PRE_LOAD = PRE_W'(CYC_PER_US - 1);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN  = 3'b010,
      ST_FIN  = 3'b100
   } srer_state_t;
endpackage

// >>> hdl/srer_completion_time_limit_timer.sv
// completion time limit timer counting whole microseconds
`timescale 1ns/1ps
module srer_completion_time_limit_timer (
   // clock and reset
   input  wire logic                       clock,
   input  wire logic                       rst_b,
   // control
   input  wire logic                       start,
   input  wire logic                       stop,
   input  wire logic [srer_pkg::LIM_W-1:0] limitUs,
   // result
   output logic                            expire
);
   logic [srer_pkg::PRE_W-1:0] pre_q;
   logic [srer_pkg::LIM_W-1:0] remain_q;
   logic                       active_q;
   logic                       expire_q;
   wire                        usTick  = active_q && (pre_q == '0);
   wire                        lastUs  = usTick && (remain_q == srer_pkg::LIM_W'(1));

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pre_q    <= '0;
         remain_q <= '0;
         active_q <= 1'b0;
         expire_q <= 1'b0;
      end else begin
         expire_q <= lastUs && !start && !stop;
         if (start) begin
            active_q <= 1'b1;
            remain_q <= limitUs;
            pre_q    <= srer_pkg::PRE_LOAD;
         end else if (stop || lastUs) begin
            active_q <= 1'b0;
         end else if (usTick) begin
            pre_q    <= srer_pkg::PRE_LOAD;
            remain_q <= remain_q - srer_pkg::LIM_W'(1);
         end else if (active_q) begin
            pre_q    <= pre_q - srer_pkg::PRE_W'(1);
         end
      end
   end

   assign expire = expire_q;

   property p_tick_spacing;
      @(posedge clock) disable iff (!rst_b)
         (usTick && !lastUs && !start && !stop) |=> (pre_q == srer_pkg::PRE_LOAD);
   endproperty
   a_tick_spacing: assert property (p_tick_spacing)
      else $error("microsecond prescaler did not reload");
endmodule // srer_completion_time_limit_timer

// >>> hdl/srer_fail_capture.sv
// first failing block address and run of suspect sectors
`timescale 1ns/1ps
module srer_fail_capture (
   // clock and reset
   input  wire logic                       clock,
   input  wire logic                       rst_b,
   // control
   input  wire logic                       start,
   input  wire logic                       errValid,
   input  wire logic [srer_pkg::LBA_W-1:0] errLba,
   // result
   output logic                            haveFail,
   output logic [srer_pkg::LBA_W-1:0]      firstLba,
   output logic [srer_pkg::CNT_W-1:0]      suspectCnt
);
   logic                       have_q;
   logic [srer_pkg::LBA_W-1:0] first_q;
   logic [srer_pkg::CNT_W-1:0] cnt_q;
   // only an error on the sector right after the run extends it
   wire nextInRun = have_q && (errLba == first_q + srer_pkg::LBA_W'(cnt_q));
   wire cntFull   = (cnt_q == '1);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         have_q  <= 1'b0;
         first_q <= '0;
         cnt_q   <= '0;
      end else if (start) begin
         have_q  <= 1'b0;
         first_q <= '0;
         cnt_q   <= '0;
      end else if (errValid && !have_q) begin
         have_q  <= 1'b1;
         first_q <= errLba;
         cnt_q   <= srer_pkg::CNT_W'(1);
      end else if (errValid && nextInRun && !cntFull) begin
         cnt_q   <= cnt_q + srer_pkg::CNT_W'(1);
      end
   end

   assign haveFail   = have_q;
   assign firstLba   = first_q;
   assign suspectCnt = cnt_q;

   property p_first_holds;
      @(posedge clock) disable iff (!rst_b)
         (have_q && errValid && !start) |=> (first_q == $past(first_q));
   endproperty
   a_first_holds: assert property (p_first_holds)
      else $error("first failing address was overwritten");
endmodule // srer_fail_capture

// >>> verif/srer_engine_model.sv
// media engine stand-in: a run of failing sectors, then end of transfer
`timescale 1ns/1ps
module srer_engine_model (
   // clock and block state
   input  wire logic        clock,
   input  wire logic        xferBusy,
   // scenario setup from the bench
   input  wire logic [47:0] baseLba,
   input  wire logic [31:0] nErr,
   input  wire logic [31:0] doneDly,
   // events to the block
   output logic             errValid,
   output logic [3:0]       errKind,
   output logic [47:0]      errLba,
   output logic             xferDone
);
   initial begin
      errValid = 1'b0;
      xferDone = 1'b0;
      errKind  = 4'h0;
      errLba   = 48'h0;
      forever begin
         @(posedge clock);
         if (xferBusy) begin
            for (int i = 0; i < nErr; i++) begin
               errValid <= 1'b1;
               errKind  <= 4'h2;
               errLba   <= baseLba + 48'(i);
               @(posedge clock);
            end
            // released lines carry junk, not the last address
            errValid <= 1'b0;
            errKind  <= 4'hD;
            errLba   <= ~errLba;
            // data errors cut the transfer short unless continuous read is on
            for (int n = 0; n < doneDly && xferBusy; n++) @(posedge clock);
            if (xferBusy) begin
               xferDone <= 1'b1;
               @(posedge clock);
               xferDone <= 1'b0;
            end
            while (xferBusy) @(posedge clock);
         end
      end
   end
endmodule // srer_engine_model

// >>> verif/srer_top_tb.sv
// self-checking bench for the stream read error report block
`timescale 1ns/1ps
module srer_top_tb;
   logic clock, rst_b, regWrEn, regRdEn, errValid, xferDone, xferBusy, rcMode, stopXfer, irq;
   logic [3:0]  regAddr, errKind;
   logic [7:0]  regWrData, regRdData;
   logic [47:0] errLba, startLba, baseLba;
   logic [15:0] sectorCount;
   int          nErr, doneDly, err_total, checks_done;
   srer_top #(.COMPLETION_TIME_LIMIT_UNIT_US(16'h0001), .COMPLETION_TIME_LIMIT_MIN_US(24'h000001)) DUT (.clock, .rst_b,
      .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .errValid, .errKind, .errLba,
      .xferDone, .xferBusy, .rcMode, .startLba, .sectorCount, .stopXfer, .irq);
   srer_engine_model engine (.clock, .xferBusy, .baseLba, .nErr, .doneDly, .errValid,
      .errKind, .errLba, .xferDone);
   task automatic chk(input string what, input logic [47:0] exp, got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clock);
      regWrEn <= 1'b0;
   endtask
   task automatic rd(input string what, input logic [3:0] a, input logic [7:0] exp);
      @(posedge clock);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRdEn <= 1'b0;
      #1 chk(what, 48'(exp), 48'(regRdData));
   endtask
   task automatic run_cmd(input logic [7:0] fPrev, fCur, input logic [47:0] a,
                          input logic [15:0] n, input int expStop);
      int stops = 0;
      wr(srer_pkg::REG_FEATURE, fPrev);
      wr(srer_pkg::REG_SECCNT, n[15:8]);
      wr(srer_pkg::REG_SECCNT, n[7:0]);
      wr(srer_pkg::REG_FEATURE, fCur);
      for (int k = 0; k < 3; k++) begin
         wr(4'(srer_pkg::REG_LBA_LO + k), a[24+8*k +: 8]);
         wr(4'(srer_pkg::REG_LBA_LO + k), a[8*k +: 8]);
      end
      wr(srer_pkg::REG_CMD_STAT, srer_pkg::CMD_READ_STREAM);
      #1 chk("startLba", a, startLba);
      chk("rcMode", 48'(fCur[6]), 48'(rcMode));
      chk("sectorCount", 48'(n), 48'(sectorCount));
      for (int i = 0; i < 2000 && xferBusy !== 1'b0; i++) begin
         @(posedge clock);
         stops += int'(stopXfer === 1'b1);
      end
      chk("xferBusy", 48'h0, 48'(xferBusy));
      chk("stopXfer", 48'(expStop), 48'(stops));
      repeat (2) @(posedge clock);
   endtask
   task automatic sc_reset;
      rd("status", srer_pkg::REG_CMD_STAT, 8'h40);
      rd("error", srer_pkg::REG_CTRL_ERR, 8'h00);
      rd("unmapped", 4'hF, 8'h00);
   endtask
   task automatic sc_stream;
      wr(srer_pkg::REG_IRQ_MASK, 8'h03);
      baseLba = 48'hA1B2C3D4E5F6;
      nErr = 3;
      doneDly = 20;
      run_cmd(8'h00, 8'h40, 48'h123456789ABC, 16'h0104, 0);
      #1 chk("irq", 48'h1, 48'(irq));
      rd("status", srer_pkg::REG_CMD_STAT, 8'h60);
      rd("error", srer_pkg::REG_CTRL_ERR, 8'h00);
      rd("log", srer_pkg::REG_ERR_LOG, 8'h40);
      rd("lbaLo", srer_pkg::REG_LBA_LO, 8'hF6);
      wr(srer_pkg::REG_CTRL_ERR, 8'h80);
      rd("lbaHiPrev", srer_pkg::REG_LBA_HI, 8'hA1);
      wr(srer_pkg::REG_CTRL_ERR, 8'h00);
      rd("count", srer_pkg::REG_SECCNT, 8'h03);
      rd("irqStat", srer_pkg::REG_IRQ_STAT, 8'h03);
      repeat (2) @(posedge clock);
      #1 chk("irq", 48'h0, 48'(irq));
   endtask
   task automatic sc_limit;
      nErr = 0;
      doneDly = 1000;
      run_cmd(8'h01, 8'h40, 48'h000000000100, 16'h0000, 1);
      rd("error", srer_pkg::REG_CTRL_ERR, 8'h01);
      rd("status", srer_pkg::REG_CMD_STAT, 8'h60);
      rd("log", srer_pkg::REG_ERR_LOG, 8'h01);
      nErr = 1;
      doneDly = 20;
      run_cmd(8'h00, 8'h00, 48'h000000000200, 16'h0001, 1);
      rd("status", srer_pkg::REG_CMD_STAT, 8'h41);
      rd("error", srer_pkg::REG_CTRL_ERR, 8'h40);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      {rst_b, regWrEn, regRdEn, regAddr, regWrData, baseLba} = '0;
      {nErr, doneDly, err_total, checks_done} = '0;
      repeat (12) @(posedge clock);
      rst_b <= 1'b1;
      sc_reset();
      sc_stream();
      sc_limit();
      final_report();
   end
   // the whole run needs well under 20000 cycles
   initial begin
      #300000;
      err_total++;
      final_report();
   end
endmodule // srer_top_tb
